// ==== rtl/gst_consts.vh ====
// Register offsets, field positions, reset values and timing constants of the slot timing block
`ifndef GST_CONSTS_VH
`define GST_CONSTS_VH

// ---------------------------------------------------------------
// Register offsets (word addresses on the host register port)
// ---------------------------------------------------------------
`define GST_ADDR_PERIOD_LOW 16'h000D
`define GST_ADDR_PERIOD_HIGH 16'h000E
`define GST_ADDR_SYS_CTRL 16'h000F
`define GST_ADDR_OP_CTRL 16'h0010

// ---------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------
`define GST_RST_PERIOD_LOW 16'h2710
`define GST_RST_PERIOD_HIGH 7'h00
`define GST_RST_CLK_SRC 2'h0
`define GST_RST_ALT_PIN 2'h0
`define GST_RST_SLOT_CNT 4'h0

// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define GST_BIT_SOFT_RESTART 15
`define GST_CLK_SRC_HI 9
`define GST_CLK_SRC_LO 8
`define GST_ALT_PIN_HI 7
`define GST_ALT_PIN_LO 6
`define GST_BIT_SLOW_CHOICE 2
`define GST_BIT_FAST_OSC_ON 1
`define GST_BIT_KHZ_OSC_ON 0
`define GST_SLOT_CNT_HI 11
`define GST_SLOT_CNT_LO 8
`define GST_BIT_RUN 0

// ---------------------------------------------------------------
// Clock source codes
// ---------------------------------------------------------------
`define GST_SRC_INTERNAL 2'h0
`define GST_SRC_EXT_LF 2'h1
`define GST_SRC_EXT_HF 2'h2
`define GST_SRC_EXT_HF_DIV 2'h3

// ---------------------------------------------------------------
// Slot and timing constants
// ---------------------------------------------------------------
`define GST_SLOT_LAST 4'hB
`define GST_PERIOD_W 23
`define GST_HF_DIV 16

`endif

// ==== rtl/gst_sync.v ====
// Two-flop synchroniser for a group of asynchronous level inputs
`timescale 1ns/100ps

module gst_sync #(
   parameter WIDTH = 1
) (
   input wire clk,
   input wire rst_b,
   input wire [WIDTH-1:0] async_in,
   output wire [WIDTH-1:0] sync_out
);

   reg [WIDTH-1:0] stage_one;
   reg [WIDTH-1:0] stage_two;

   genvar bit_i;
   generate
      for (bit_i = 0; bit_i < WIDTH; bit_i = bit_i + 1) begin : g_bit
         // First stage feeds only the second stage to let metastability settle
         always @(posedge clk or negedge rst_b) begin
            if (!rst_b) begin
               stage_one[bit_i] <= 1'b0;
               stage_two[bit_i] <= 1'b0;
            end else begin
               stage_one[bit_i] <= async_in[bit_i];
               stage_two[bit_i] <= stage_one[bit_i];
            end
         end
      end
   endgenerate

   assign sync_out = stage_two;

endmodule

// ==== rtl/gst_top.v ====
// Global slot timing configuration: period counter, clock source selection, soft restart and slot sequencing
//
// Summary of operation
// - Sampling period is a 23-bit count: low sixteen and high seven bits.
// - Periods start at slow clock frequency divided by the period count.
// - Low period field resets to 0x2710, 100 Hz from a 1 MHz slow clock.
// - Writing the soft restart bit halts activity and restores register defaults.
// - Soft restart leaves the host serial port untouched.
// - Source code 00 uses both internal oscillators; 01 uses an external slow clock.
// - Code 2 external fast plus internal slow; code 3 slow derived from external fast.
// - Alternate clock pin field routes pin 0 to 3 for codes 00 to 11.
// - Slow clock choice bit: zero picks 32 kHz oscillator, one picks 1 MHz.
// - Bit 1 enables the 1 MHz oscillator; software keeps it on while used.
// - Bit 0 enables the 32 kHz oscillator; software keeps it on while used.
// - Slot count n runs slots A through the (n+1)th letter each period, never past slot L.
// - Slot count reset value 0000 runs slot A only.
// - Run bit zero means standby; one runs enabled slots every period.
`timescale 1ns/100ps
`include "gst_consts.vh"

module gst_top #(
   parameter HF_DIV = `GST_HF_DIV
) (
   input wire clk,
   input wire rst_b,
   input wire [15:0] reg_addr,
   input wire [15:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   output reg [15:0] reg_rdata,
   output reg reg_rd_valid,
   input wire osc_khz_in,
   input wire osc_fast_in,
   input wire [3:0] gpio_in,
   output reg kilohertz_osc_on,
   output reg fast_slow_osc_on,
   output reg ext_fast_clk_used,
   output reg ext_slow_clk_used,
   output reg [1:0] alternate_clock_pin,
   output reg afe_halt,
   output reg period_start,
   output reg slot_go,
   output reg [3:0] slot_index
);

   // ---------------------------------------------------------------
   // Configuration registers
   // ---------------------------------------------------------------
   reg [15:0] period_count_low;
   reg [6:0] period_count_high;
   reg [1:0] clock_source_select;
   reg slow_clock_choice;
   reg [3:0] slot_count_select;
   reg run_standby_bit;

   wire soft_restart;
   wire [`GST_PERIOD_W-1:0] period_total;

   // Soft restart takes effect on the very write that sets the bit
   assign soft_restart = reg_wr && (reg_addr == `GST_ADDR_SYS_CTRL) && reg_wdata[`GST_BIT_SOFT_RESTART];
   assign period_total = {period_count_high, period_count_low};

   // Register writes; a soft restart overrides every field of the same write
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         period_count_low <= `GST_RST_PERIOD_LOW;
         period_count_high <= `GST_RST_PERIOD_HIGH;
         clock_source_select <= `GST_RST_CLK_SRC;
         alternate_clock_pin <= `GST_RST_ALT_PIN;
         slow_clock_choice <= 1'b0;
         fast_slow_osc_on <= 1'b0;
         kilohertz_osc_on <= 1'b0;
         slot_count_select <= `GST_RST_SLOT_CNT;
         run_standby_bit <= 1'b0;
      end else if (soft_restart) begin
         period_count_low <= `GST_RST_PERIOD_LOW;
         period_count_high <= `GST_RST_PERIOD_HIGH;
         clock_source_select <= `GST_RST_CLK_SRC;
         alternate_clock_pin <= `GST_RST_ALT_PIN;
         slow_clock_choice <= 1'b0;
         fast_slow_osc_on <= 1'b0;
         kilohertz_osc_on <= 1'b0;
         slot_count_select <= `GST_RST_SLOT_CNT;
         run_standby_bit <= 1'b0;
      end else if (reg_wr) begin
         case (reg_addr)
            `GST_ADDR_PERIOD_LOW: begin
               period_count_low <= reg_wdata;
            end
            `GST_ADDR_PERIOD_HIGH: begin
               period_count_high <= reg_wdata[6:0];
            end
            `GST_ADDR_SYS_CTRL: begin
               clock_source_select <= reg_wdata[`GST_CLK_SRC_HI:`GST_CLK_SRC_LO];
               alternate_clock_pin <= reg_wdata[`GST_ALT_PIN_HI:`GST_ALT_PIN_LO];
               slow_clock_choice <= reg_wdata[`GST_BIT_SLOW_CHOICE];
               fast_slow_osc_on <= reg_wdata[`GST_BIT_FAST_OSC_ON];
               kilohertz_osc_on <= reg_wdata[`GST_BIT_KHZ_OSC_ON];
            end
            `GST_ADDR_OP_CTRL: begin
               slot_count_select <= reg_wdata[`GST_SLOT_CNT_HI:`GST_SLOT_CNT_LO];
               run_standby_bit <= reg_wdata[`GST_BIT_RUN];
            end
            default: begin
               run_standby_bit <= run_standby_bit;
            end
         endcase
      end
   end

   // ---------------------------------------------------------------
   // Host read port
   // ---------------------------------------------------------------
   reg [15:0] next_rdata;

   // Reserved bits and the self-clearing restart bit read as zero
   always @* begin
      next_rdata = 16'h0000;
      case (reg_addr)
         `GST_ADDR_PERIOD_LOW: begin
            next_rdata = period_count_low;
         end
         `GST_ADDR_PERIOD_HIGH: begin
            next_rdata = {9'h000, period_count_high};
         end
         `GST_ADDR_SYS_CTRL: begin
            next_rdata = {6'h00, clock_source_select, alternate_clock_pin, 3'h0,
               slow_clock_choice, fast_slow_osc_on, kilohertz_osc_on};
         end
         `GST_ADDR_OP_CTRL: begin
            next_rdata = {4'h0, slot_count_select, 7'h00, run_standby_bit};
         end
         default: begin
            next_rdata = 16'h0000;
         end
      endcase
   end

   // Read data is not touched by soft restart so a host transfer survives it
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         reg_rdata <= 16'h0000;
         reg_rd_valid <= 1'b0;
      end else begin
         reg_rd_valid <= reg_rd;
         if (reg_rd) begin
            reg_rdata <= next_rdata;
         end
      end
   end

   // ---------------------------------------------------------------
   // Clock inputs and slow tick selection
   // ---------------------------------------------------------------
   wire [5:0] clk_sync;
   reg [5:0] clk_sync_d;
   wire [5:0] clk_rise;
   wire ext_pin_rise;
   reg [15:0] hf_div_cnt;
   reg hf_div_tick;
   reg slow_tick;

   // Oscillator and pin clocks are far slower than clk and are sampled as levels
   gst_sync #(
      .WIDTH(6)
   ) u_clk_sync (
      .clk(clk),
      .rst_b(rst_b),
      .async_in({gpio_in, osc_fast_in, osc_khz_in}),
      .sync_out(clk_sync)
   );

   // Edge detection runs on the synchronised copy only
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         clk_sync_d <= 6'h00;
      end else begin
         clk_sync_d <= clk_sync;
      end
   end

   assign clk_rise = clk_sync & ~clk_sync_d;
   assign ext_pin_rise = clk_rise[3'd2 + {1'b0, alternate_clock_pin}];

   // Divider that derives slow ticks from the external fast clock
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         hf_div_cnt <= 16'h0000;
         hf_div_tick <= 1'b0;
      end else begin
         hf_div_tick <= 1'b0;
         if (soft_restart) begin
            hf_div_cnt <= 16'h0000;
         end else if (ext_pin_rise) begin
            if (hf_div_cnt == HF_DIV[15:0] - 16'h0001) begin
               hf_div_cnt <= 16'h0000;
               hf_div_tick <= 1'b1;
            end else begin
               hf_div_cnt <= hf_div_cnt + 16'h0001;
            end
         end
      end
   end

   // Source multiplexer; the selected oscillator gives no ticks unless enabled
   always @* begin
      case (clock_source_select)
         `GST_SRC_EXT_LF: begin
            slow_tick = ext_pin_rise;
         end
         `GST_SRC_EXT_HF_DIV: begin
            slow_tick = hf_div_tick;
         end
         default: begin
            if (slow_clock_choice) begin
               slow_tick = clk_rise[1] & fast_slow_osc_on;
            end else begin
               slow_tick = clk_rise[0] & kilohertz_osc_on;
            end
         end
      endcase
   end

   // Source status outputs for the analog clock switches
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         ext_fast_clk_used <= 1'b0;
         ext_slow_clk_used <= 1'b0;
      end else begin
         ext_fast_clk_used <= clock_source_select[1];
         ext_slow_clk_used <= (clock_source_select == `GST_SRC_EXT_LF);
      end
   end

   // ---------------------------------------------------------------
   // Period counter
   // ---------------------------------------------------------------
   reg [`GST_PERIOD_W-1:0] period_cnt;
   wire period_wrap;

   // A zero period is blocked from wrapping, so the counter free-runs and no period starts
   assign period_wrap = slow_tick && (period_total != {`GST_PERIOD_W{1'b0}})
      && (period_cnt >= period_total - {{(`GST_PERIOD_W-1){1'b0}}, 1'b1});

   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         period_cnt <= {`GST_PERIOD_W{1'b0}};
         period_start <= 1'b0;
         afe_halt <= 1'b1;
      end else begin
         period_start <= 1'b0;
         afe_halt <= ~run_standby_bit | soft_restart;
         if (soft_restart || !run_standby_bit) begin
            period_cnt <= {`GST_PERIOD_W{1'b0}};
         end else if (period_wrap) begin
            period_cnt <= {`GST_PERIOD_W{1'b0}};
            period_start <= 1'b1;
         end else if (slow_tick) begin
            period_cnt <= period_cnt + {{(`GST_PERIOD_W-1){1'b0}}, 1'b1};
         end
      end
   end

   // ---------------------------------------------------------------
   // Slot sequencer
   // ---------------------------------------------------------------
   localparam SEQ_IDLE = 1'b0;
   localparam SEQ_WALK = 1'b1;

   reg seq_state;
   wire [3:0] slot_last;

   // Undefined counts are clamped so the walk never passes slot L
   assign slot_last = (slot_count_select > `GST_SLOT_LAST) ? `GST_SLOT_LAST : slot_count_select;

   // One slot strobe per clock from A up to the last enabled slot
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         seq_state <= SEQ_IDLE;
         slot_go <= 1'b0;
         slot_index <= 4'h0;
      end else begin
         slot_go <= 1'b0;
         if (soft_restart || !run_standby_bit) begin
            seq_state <= SEQ_IDLE;
            slot_index <= 4'h0;
         end else begin
            case (seq_state)
               SEQ_IDLE: begin
                  if (period_start) begin
                     seq_state <= SEQ_WALK;
                     slot_index <= 4'h0;
                     slot_go <= 1'b1;
                  end
               end
               SEQ_WALK: begin
                  if (slot_index >= slot_last) begin
                     seq_state <= SEQ_IDLE;
                  end else begin
                     slot_index <= slot_index + 4'h1;
                     slot_go <= 1'b1;
                  end
               end
               default: begin
                  seq_state <= SEQ_IDLE;
               end
            endcase
         end
      end
   end

endmodule

// ==== verification/gst_top_monitor.sv ====
// Port checker for the slot timing block, bound onto gst_top
`timescale 1ns/100ps

module gst_top_monitor (
   input wire clk,
   input wire rst_b,
   input wire [15:0] reg_addr,
   input wire [15:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   input wire [15:0] reg_rdata,
   input wire reg_rd_valid,
   input wire osc_khz_in,
   input wire osc_fast_in,
   input wire [3:0] gpio_in,
   input wire kilohertz_osc_on,
   input wire fast_slow_osc_on,
   input wire ext_fast_clk_used,
   input wire ext_slow_clk_used,
   input wire [1:0] alternate_clock_pin,
   input wire afe_halt,
   input wire period_start,
   input wire slot_go,
   input wire [3:0] slot_index
);
   // ----------
   // Properties
   // ----------
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_b);

   // A quiet cycle after the write keeps a second write from masking the result
   sequence s_cfg;
      reg_wr && reg_addr == 16'h000F && !reg_wdata[15] ##1 !reg_wr;
   endsequence
   sequence s_rst;
      reg_wr && reg_addr == 16'h000F && reg_wdata[15] ##1 !reg_wr;
   endsequence
   property p_osc_on;
      s_cfg |-> ##1 {fast_slow_osc_on, kilohertz_osc_on} == $past(reg_wdata[1:0], 2);
   endproperty
   a_osc_on: assert property (p_osc_on) else $error("oscillator enables wrong");
   property p_alt_pin;
      s_cfg |-> ##1 alternate_clock_pin == $past(reg_wdata[7:6], 2);
   endproperty
   a_alt_pin: assert property (p_alt_pin) else $error("alternate pin wrong");
   property p_ext_fast;
      s_cfg |-> ##1 ext_fast_clk_used == $past(reg_wdata[9], 2);
   endproperty
   a_ext_fast: assert property (p_ext_fast) else $error("external fast flag wrong");
   property p_ext_slow;
      s_cfg |-> ##1 ext_slow_clk_used == ($past(reg_wdata[9:8], 2) == 2'h1);
   endproperty
   a_ext_slow: assert property (p_ext_slow) else $error("external slow flag wrong");
   property p_restart;
      s_rst |-> afe_halt ##1 (afe_halt && !kilohertz_osc_on && !fast_slow_osc_on && alternate_clock_pin == 2'h0);
   endproperty
   a_restart: assert property (p_restart) else $error("soft restart left state");
   property p_rd_high;
      reg_rd && reg_addr == 16'h000E |=> reg_rd_valid && reg_rdata[15:7] == 9'h000;
   endproperty
   a_rd_high: assert property (p_rd_high) else $error("high period read wrong");
   property p_rd_unmapped;
      reg_rd && reg_addr == 16'h0011 |=> reg_rd_valid && reg_rdata == 16'h0000;
   endproperty
   a_rd_unmapped: assert property (p_rd_unmapped) else $error("unmapped read not zero");
   property p_walk_first;
      period_start |=> slot_go && slot_index == 4'h0;
   endproperty
   a_walk_first: assert property (p_walk_first) else $error("walk did not start at A");
   property p_walk_next;
      slot_go && !$past(period_start) |-> $past(slot_go) && slot_index == $past(slot_index) + 4'h1;
   endproperty
   a_walk_next: assert property (p_walk_next) else $error("slot order broken");
   property p_standby;
      afe_halt && $past(afe_halt) |-> !period_start;
   endproperty
   a_standby: assert property (p_standby) else $error("period in standby");
   c_period: cover property (period_start);
   c_last_slot: cover property (slot_go && slot_index == 4'hB);
   c_restart: cover property (s_rst);
endmodule

bind gst_top gst_top_monitor i_mon (.clk(clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
   .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rd_valid(reg_rd_valid), .osc_khz_in(osc_khz_in),
   .osc_fast_in(osc_fast_in), .gpio_in(gpio_in), .kilohertz_osc_on(kilohertz_osc_on),
   .fast_slow_osc_on(fast_slow_osc_on), .ext_fast_clk_used(ext_fast_clk_used), .ext_slow_clk_used(ext_slow_clk_used),
   .alternate_clock_pin(alternate_clock_pin), .afe_halt(afe_halt), .period_start(period_start), .slot_go(slot_go),
   .slot_index(slot_index));

// ==== verification/gst_top_tb.sv ====
// Self-checking bench for the slot timing block
`timescale 1ns/100ps

module gst_top_tb;
   reg clk, rst_b, reg_wr, reg_rd, osc_khz_in, osc_fast_in;
   reg [15:0] reg_addr, reg_wdata;
   reg [3:0] gpio_in;
   wire [15:0] reg_rdata;
   wire reg_rd_valid, kilohertz_osc_on, fast_slow_osc_on, ext_fast_clk_used, ext_slow_clk_used;
   wire afe_halt, period_start, slot_go;
   wire [1:0] alternate_clock_pin;
   wire [3:0] slot_index;
   integer miscompares = 0;
   integer total_checks = 0;
   integer cyc = 0;
   integer n, t, g;
   // Source rows: code, pin, fast-internal choice, slot count
   logic [1:0] code [0:5] = '{0, 1, 2, 3, 1, 1};
   logic [1:0] pin [0:5] = '{0, 1, 0, 3, 0, 2};
   logic b2 [0:5] = '{0, 0, 1, 0, 0, 1};
   logic [3:0] slots [0:5] = '{0, 3, 5, 11, 1, 7};
   wire [15:0] cfg_out = {10'h000, ext_fast_clk_used, ext_slow_clk_used, alternate_clock_pin, fast_slow_osc_on,
      kilohertz_osc_on};

   gst_top #(.HF_DIV(2)) i_dut (.clk(clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rd_valid(reg_rd_valid),
      .osc_khz_in(osc_khz_in), .osc_fast_in(osc_fast_in), .gpio_in(gpio_in), .kilohertz_osc_on(kilohertz_osc_on),
      .fast_slow_osc_on(fast_slow_osc_on), .ext_fast_clk_used(ext_fast_clk_used),
      .ext_slow_clk_used(ext_slow_clk_used), .alternate_clock_pin(alternate_clock_pin), .afe_halt(afe_halt),
      .period_start(period_start), .slot_go(slot_go), .slot_index(slot_index));

   // -----------------
   // Clock and sources
   // -----------------
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   // Each GPIO gets its own period so a misrouted pin changes the measured period
   always @(negedge clk) begin
      cyc <= cyc + 1;
      osc_fast_in <= cyc[2];
      osc_khz_in <= cyc[3];
      for (g = 0; g < 4; g = g + 1) gpio_in[g] <= ((cyc / (g + 2)) % 2) == 1;
   end

   // -----
   // Tasks
   // -----
   task chk(input [15:0] got, input [15:0] exp);
      begin
         total_checks = total_checks + 1;
         if (got !== exp) begin
            miscompares = miscompares + 1;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
         end
      end
   endtask

   task wr(input [15:0] a, input [15:0] d);
      begin
         @(negedge clk);
         reg_wr = 1'b1;
         reg_addr = a;
         reg_wdata = d;
         @(negedge clk);
         reg_wr = 1'b0;
      end
   endtask

   // Read valid stands for one cycle only, so the answer is sampled at the next falling edge
   task rd(input [15:0] a, input [15:0] e);
      begin
         @(negedge clk);
         reg_rd = 1'b1;
         reg_addr = a;
         @(negedge clk);
         reg_rd = 1'b0;
         chk({15'h0000, reg_rd_valid}, 16'h0001);
         chk(reg_rdata, e);
      end
   endtask

   // Waits for a period start, checks the slot walk, then measures the spacing to the next start
   task per(input integer p, input [3:0] s);
      integer c, k;
      begin
         c = 0;
         while (period_start !== 1'b1 && c < 3000) begin
            @(negedge clk);
            c = c + 1;
         end
         for (k = 0; k <= s; k = k + 1) begin
            @(negedge clk);
            chk({11'h000, slot_go, slot_index}, {12'h001, k[3:0]});
         end
         @(negedge clk);
         chk({15'h0000, slot_go}, 16'h0000);
         c = s + 2;
         while (period_start !== 1'b1 && c < 3000) begin
            @(negedge clk);
            c = c + 1;
         end
         chk(c[15:0], p[15:0]);
      end
   endtask

   task quiet;
      integer c, k;
      begin
         c = 0;
         for (k = 0; k < 200; k = k + 1) begin
            @(negedge clk);
            if (period_start === 1'b1) c = c + 1;
         end
         chk(c[15:0], 16'h0000);
      end
   endtask

   task report_and_stop;
      begin
         $display("checks=%0d miscompares=%0d", total_checks, miscompares);
         if (miscompares == 0 && total_checks > 0) begin
            $display("RESULT: PASS");
         end else begin
            $display("RESULT: FAIL");
         end
         $finish;
      end
   endtask

   // Whole run is under 1500 cycles; the limit of 10000 cycles leaves wide margin
   initial begin
      #40000;
      miscompares = miscompares + 1;
      report_and_stop;
   end

   // ---------
   // Sequences
   // ---------
   initial begin
      rst_b = 1'b0;
      // Oscillator and pin inputs belong to the source process alone
      {reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
      repeat (2) @(negedge clk);
      rst_b = 1'b1;
      chk({15'h0000, afe_halt}, 16'h0001);
      rd(16'h000D, 16'h2710);
      rd(16'h000E, 16'h0000);
      rd(16'h000F, 16'h0000);
      rd(16'h0010, 16'h0000);
      rd(16'h0011, 16'h0000);
      wr(16'h000E, 16'hFFFF);
      rd(16'h000E, 16'h007F);
      wr(16'h000F, 16'h7FFF);
      rd(16'h000F, 16'h03C7);
      wr(16'h0010, 16'hF000);
      rd(16'h0010, 16'h0000);
      wr(16'h000E, 16'h0000);
      wr(16'h000D, 16'h0004);
      for (n = 0; n < 6; n = n + 1) begin
         wr(16'h000F, {6'h00, code[n], pin[n], 3'h0, b2[n], 2'h3});
         @(negedge clk);
         chk(cfg_out, {10'h000, code[n][1], code[n] == 2'h1, pin[n], 2'h3});
         wr(16'h0010, {4'h0, slots[n], 8'h01});
         t = (code[n] == 2'h1) ? 2 * (pin[n] + 2) : (code[n] == 2'h3) ? 4 * (pin[n] + 2) : (b2[n] ? 8 : 16);
         per(4 * t, slots[n]);
         wr(16'h0010, 16'h0000);
      end
      quiet;
      wr(16'h000F, 16'h0005);
      wr(16'h0010, 16'h0001);
      quiet;
      wr(16'h000F, 16'h0002);
      quiet;
      wr(16'h000F, 16'h0007);
      wr(16'h000D, 16'h0009);
      wr(16'h0010, 16'h0B01);
      rd(16'h000D, 16'h0009);
      wr(16'h000F, 16'h8007);
      chk({15'h0000, afe_halt}, 16'h0001);
      chk(reg_rdata, 16'h0009);
      rd(16'h000D, 16'h2710);
      rd(16'h000F, 16'h0000);
      rd(16'h0010, 16'h0000);
      report_and_stop;
   end
endmodule
